// File: src/rcr_regs.sv
// Write-only control register bank of a stereo broadcast receiver.
// Assumes one-cycle write strobes synchronous to mclk_i and event pulses from the decoder.
// Overview of operation
// [RL1] A set mute bit silences the audio output; reset leaves it unmuted.
// [RL2] The time-constant bit selects 50 us when 0 and 75 us when 1, resetting to 1.
// [RL3] The digital gain field attenuates 1 dB per code from 0 dB at 000 to -5 dB at 101.
// [RL4] The analog gain field gives 0 dB at 111 and 6 dB less per lower code to -42 dB.
// [RL5] The 11-bit reference divisor joins the first register with three low bits of the second.
// [RL6] Software programs the divisor as crystal frequency over 32.768 kHz; it resets to 1.
// [RL7] The 13-bit offset word joins five upper bits of the second register with the third.
// [RL8] Software computes the offset word from the crystal; its upper byte resets to 0x5c.
// [RL9] A data-group load with its enable set in receive mode gives a 4.5 ms low interrupt.
// [RL10] A finished channel scan with its enable set in receive mode gives the same pulse.
// [RL11] The format bit accepts standard blocks only when 0 and also paging blocks when 1.
// [RL12] A set tone bit with receive requested feeds a 1 kHz tone instead of received audio.
// [RL13] The three reserved interrupt-register bits are written zero and ignored.
// [RL14] The group-update bit toggles per complete group, with the interrupt starting alongside only when its enable is set in receive mode.
`timescale 1ns/100ps
module rcr_regs (
	input wire logic mclk_i,
	input wire logic rst_n_i,
	input wire logic wr_en_i,
	input wire logic [7:0] wr_addr_i,
	input wire logic [7:0] wr_data_i,
	input wire logic receive_request_i,
	input wire logic group_loaded_i,
	input wire logic channel_scan_done_i,
	output logic audio_mute_o,
	output logic deemphasis_time_select_o,
	output logic [2:0] digital_gain_o,
	output logic [2:0] analog_gain_o,
	output logic [10:0] ref_divisor_o,
	output logic [12:0] synth_offset_o,
	output logic paging_block_format_o,
	output logic test_tone_o,
	output logic data_alt_rate_mode_o,
	output logic group_update_o,
	output logic int_n_o
);

////////////////////////////////////////////////////////////////////////////////
// Write decode
localparam int NREG = 5;
localparam int SEL_VOL = 0;
localparam int SEL_DIV0 = 1;
localparam int SEL_DIV1 = 2;
localparam int SEL_DIV2 = 3;
localparam int SEL_INT = 4;
localparam logic [NREG-1:0][7:0] REG_ADDR = {
	rcr_pkg::ADDR_INT,
	rcr_pkg::ADDR_DIV2,
	rcr_pkg::ADDR_DIV1,
	rcr_pkg::ADDR_DIV0,
	rcr_pkg::ADDR_VOL
};

logic [NREG-1:0] sel;

// One select per mapped address; any other address is dropped
generate
	for (genvar g = 0; g < NREG; g++) begin : g_sel
		assign sel[g] = wr_en_i & (wr_addr_i == REG_ADDR[g]);
	end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// Register storage
logic [7:0] vol_r;
logic [7:0] div0_r;
logic [7:0] div1_r;
logic [7:0] div2_r;
logic [7:0] int_r;

// Volume and de-emphasis register
always_ff @(posedge mclk_i or negedge rst_n_i) begin
	if (!rst_n_i) begin
		vol_r <= rcr_pkg::VOL_RST;
	end else if (sel[SEL_VOL]) begin
		vol_r <= wr_data_i;
	end
end

// Divisor low byte
always_ff @(posedge mclk_i or negedge rst_n_i) begin
	if (!rst_n_i) begin
		div0_r <= rcr_pkg::DIV0_RST;
	end else if (sel[SEL_DIV0]) begin
		div0_r <= wr_data_i; // [RL6]
	end
end

// Divisor high bits and offset low bits
always_ff @(posedge mclk_i or negedge rst_n_i) begin
	if (!rst_n_i) begin
		div1_r <= rcr_pkg::DIV1_RST;
	end else if (sel[SEL_DIV1]) begin
		div1_r <= wr_data_i;
	end
end

// Offset high byte
always_ff @(posedge mclk_i or negedge rst_n_i) begin
	if (!rst_n_i) begin
		div2_r <= rcr_pkg::DIV2_RST;
	end else if (sel[SEL_DIV2]) begin
		div2_r <= wr_data_i; // [RL8]
	end
end

// Interrupt and mode register; reserved bits never stored
always_ff @(posedge mclk_i or negedge rst_n_i) begin
	if (!rst_n_i) begin
		int_r <= rcr_pkg::INT_RST;
	end else if (sel[SEL_INT]) begin
		int_r <= {wr_data_i[7:3], 3'h0}; // [RL13]
	end
end

////////////////////////////////////////////////////////////////////////////////
// Field extraction
logic mute_nxt;
logic tc_nxt;
logic [2:0] dig_nxt;
logic [2:0] ana_nxt;
logic [10:0] div_nxt;
logic [12:0] ofs_nxt;
logic fmt_nxt;
logic tone_nxt;
logic alt_nxt;

assign mute_nxt = vol_r[rcr_pkg::VOL_MUTE_BIT]; // [RL1]
assign tc_nxt = vol_r[rcr_pkg::VOL_TC_BIT]; // [RL2]
assign dig_nxt = vol_r[rcr_pkg::VOL_DIG_LSB +: 3]; // [RL3]
assign ana_nxt = vol_r[rcr_pkg::VOL_ANA_LSB +: 3]; // [RL4]
assign div_nxt = {div1_r[2:0], div0_r}; // [RL5]
assign ofs_nxt = {div2_r, div1_r[7:3]}; // [RL7]
assign fmt_nxt = int_r[rcr_pkg::INT_FMT_BIT]; // [RL11]
assign tone_nxt = int_r[rcr_pkg::INT_TONE_BIT] & receive_request_i; // [RL12]
assign alt_nxt = int_r[rcr_pkg::INT_ALT_BIT];

////////////////////////////////////////////////////////////////////////////////
// Field outputs

// Mute
always_ff @(posedge mclk_i or negedge rst_n_i) begin
	if (!rst_n_i) begin
		audio_mute_o <= rcr_pkg::VOL_RST[rcr_pkg::VOL_MUTE_BIT];
	end else begin
		audio_mute_o <= mute_nxt; // [RL1]
	end
end

// De-emphasis time constant
always_ff @(posedge mclk_i or negedge rst_n_i) begin
	if (!rst_n_i) begin
		deemphasis_time_select_o <= rcr_pkg::VOL_RST[rcr_pkg::VOL_TC_BIT];
	end else begin
		deemphasis_time_select_o <= tc_nxt; // [RL2]
	end
end

// Digital gain
always_ff @(posedge mclk_i or negedge rst_n_i) begin
	if (!rst_n_i) begin
		digital_gain_o <= rcr_pkg::VOL_RST[rcr_pkg::VOL_DIG_LSB +: 3];
	end else begin
		digital_gain_o <= dig_nxt; // [RL3]
	end
end

// Analog gain
always_ff @(posedge mclk_i or negedge rst_n_i) begin
	if (!rst_n_i) begin
		analog_gain_o <= rcr_pkg::VOL_RST[rcr_pkg::VOL_ANA_LSB +: 3];
	end else begin
		analog_gain_o <= ana_nxt; // [RL4]
	end
end

// Reference divisor
always_ff @(posedge mclk_i or negedge rst_n_i) begin
	if (!rst_n_i) begin
		ref_divisor_o <= {rcr_pkg::DIV1_RST[2:0], rcr_pkg::DIV0_RST};
	end else begin
		ref_divisor_o <= div_nxt; // [RL5]
	end
end

// Synthesizer offset word
always_ff @(posedge mclk_i or negedge rst_n_i) begin
	if (!rst_n_i) begin
		synth_offset_o <= {rcr_pkg::DIV2_RST, rcr_pkg::DIV1_RST[7:3]};
	end else begin
		synth_offset_o <= ofs_nxt; // [RL7]
	end
end

// Stream format
always_ff @(posedge mclk_i or negedge rst_n_i) begin
	if (!rst_n_i) begin
		paging_block_format_o <= rcr_pkg::INT_RST[rcr_pkg::INT_FMT_BIT];
	end else begin
		paging_block_format_o <= fmt_nxt; // [RL11]
	end
end

// Test tone, only while receiving
always_ff @(posedge mclk_i or negedge rst_n_i) begin
	if (!rst_n_i) begin
		test_tone_o <= rcr_pkg::INT_RST[rcr_pkg::INT_TONE_BIT];
	end else begin
		test_tone_o <= tone_nxt; // [RL12]
	end
end

// Alternate data rate
always_ff @(posedge mclk_i or negedge rst_n_i) begin
	if (!rst_n_i) begin
		data_alt_rate_mode_o <= rcr_pkg::INT_RST[rcr_pkg::INT_ALT_BIT];
	end else begin
		data_alt_rate_mode_o <= alt_nxt;
	end
end

////////////////////////////////////////////////////////////////////////////////
// Interrupt sources and group toggle
logic data_fire;
logic scan_fire;
logic fire;
logic group_nxt;

assign data_fire = receive_request_i & group_loaded_i & int_r[rcr_pkg::INT_DATA_EN_BIT]; // [RL9]
assign scan_fire = receive_request_i & channel_scan_done_i & int_r[rcr_pkg::INT_SCAN_EN_BIT]; // [RL10]
assign fire = data_fire | scan_fire;
assign group_nxt = group_update_o ^ group_loaded_i; // [RL14]

// Toggles on every group, enabled or not
always_ff @(posedge mclk_i or negedge rst_n_i) begin
	if (!rst_n_i) begin
		group_update_o <= 1'b0;
	end else begin
		group_update_o <= group_nxt; // [RL14]
	end
end

////////////////////////////////////////////////////////////////////////////////
// Interrupt pulse; a new event restarts the full length
localparam logic [17:0] PULSE_CYC = 18'(rcr_pkg::INT_PULSE_CYC);
logic [17:0] pulse_cnt_r;
logic [17:0] pulse_cnt_nxt;
logic int_n_nxt;

always_comb begin
	pulse_cnt_nxt = pulse_cnt_r;
	if (fire) begin
		pulse_cnt_nxt = PULSE_CYC - 18'h1;
	end else if (pulse_cnt_r != 18'h0) begin
		pulse_cnt_nxt = pulse_cnt_r - 18'h1;
	end
end

assign int_n_nxt = ~(fire | (pulse_cnt_r != 18'h0)); // [RL9] [RL10]

// Remaining low cycles
always_ff @(posedge mclk_i or negedge rst_n_i) begin
	if (!rst_n_i) begin
		pulse_cnt_r <= 18'h0;
	end else begin
		pulse_cnt_r <= pulse_cnt_nxt;
	end
end

// Pulse starts on the same edge as the group toggle
always_ff @(posedge mclk_i or negedge rst_n_i) begin
	if (!rst_n_i) begin
		int_n_o <= 1'b1;
	end else begin
		int_n_o <= int_n_nxt; // [RL14]
	end
end

endmodule // rcr_regs

// File: src/rcr_pkg.sv
// Package for the receiver control register bank.
// Assumes an 8-bit register write port and a 40 MHz reference clock.
package rcr_pkg;
	localparam logic [7:0] ADDR_VOL = 8'h14;
	localparam logic [7:0] ADDR_DIV0 = 8'h15;
	localparam logic [7:0] ADDR_DIV1 = 8'h16;
	localparam logic [7:0] ADDR_DIV2 = 8'h17;
	localparam logic [7:0] ADDR_INT = 8'h18;
	localparam logic [7:0] VOL_RST = 8'h47;
	localparam logic [7:0] DIV0_RST = 8'h01;
	localparam logic [7:0] DIV1_RST = 8'h08;
	localparam logic [7:0] DIV2_RST = 8'h5c;
	localparam logic [7:0] INT_RST = 8'h20;
	localparam int VOL_MUTE_BIT = 7;
	localparam int VOL_TC_BIT = 6;
	localparam int VOL_DIG_LSB = 3;
	localparam int VOL_ANA_LSB = 0;
	localparam int INT_DATA_EN_BIT = 7;
	localparam int INT_SCAN_EN_BIT = 6;
	localparam int INT_FMT_BIT = 5;
	localparam int INT_TONE_BIT = 4;
	localparam int INT_ALT_BIT = 3;
	localparam int CLK_HZ = 40000000;
	localparam int INT_PULSE_US = 4500;
	localparam int INT_PULSE_CYC = CLK_HZ / 1000000 * INT_PULSE_US;
endpackage

// File: dv/rcr_regs_props.sv
// Assertions on the register bank ports.
// Bound into rcr_regs.
`timescale 1ns/100ps
module rcr_regs_props (
	input wire logic mclk_i, rst_n_i, wr_en_i, group_loaded_i, channel_scan_done_i,
	input wire logic receive_request_i, audio_mute_o, group_update_o, int_n_o,
	input wire logic [7:0] wr_addr_i, wr_data_i,
	input wire logic [2:0] digital_gain_o,
	input wire logic [10:0] ref_divisor_o,
	input wire logic [12:0] synth_offset_o
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!rst_n_i);
	wire [7:0] a = wr_en_i ? wr_addr_i : 8'h00;
	wire [7:0] d = wr_data_i;
	chk_mute_set: assert property (a == 8'h14 |-> ##2 audio_mute_o == $past(d[7], 2))
		else $error("mute");
	chk_gain_set: assert property (a == 8'h14 |-> ##2 digital_gain_o == $past(d[5:3], 2))
		else $error("gain");
	chk_div_lo: assert property (a == 8'h15 |-> ##2 ref_divisor_o[7:0] == $past(d, 2))
		else $error("div lo");
	chk_div_hi: assert property (a == 8'h16 |-> ##2 ref_divisor_o[10:8] == $past(d[2:0], 2))
		else $error("div hi");
	chk_ofs_lo: assert property (a == 8'h16 |-> ##2 synth_offset_o[4:0] == $past(d[7:3], 2))
		else $error("ofs lo");
	chk_ofs_hi: assert property (a == 8'h17 |-> ##2 synth_offset_o[12:5] == $past(d, 2))
		else $error("ofs hi");
	chk_upd_flip: assert property (group_loaded_i |=>
		group_update_o != $past(group_update_o)) else $error("upd");
	chk_irq_cause: assert property ($fell(int_n_o) |->
		$past(receive_request_i && (group_loaded_i || channel_scan_done_i))) else $error("irq");
endmodule // rcr_regs_props
bind rcr_regs rcr_regs_props chk (.*);

// File: dv/rcr_host.sv
// Host model issuing one-cycle register writes.
`timescale 1ns/100ps
module rcr_host (
	input wire logic mclk_i,
	output logic wr_en_o = 0,
	output logic [7:0] wr_addr_o = 0,
	output logic [7:0] wr_data_o = 0
);
	task automatic wr(input logic [7:0] a, d);
		{wr_en_o, wr_addr_o} <= {1'b1, a};
		wr_data_o <= a == 8'h18 ? d & 8'hf8 : d;
		@(posedge mclk_i);
		{wr_en_o, wr_data_o} <= {1'b0, ~d};
	endtask
endmodule // rcr_host

// File: dv/test_receiver_control_registers.sv
// Random writes, events and resets on the bank.
`timescale 1ns/100ps
module test_receiver_control_registers;
	logic mclk_i = 0, rst_n_i = 0, wr_en_i, receive_request_i = 0, group_loaded_i = 0;
	logic channel_scan_done_i = 0, audio_mute_o, deemphasis_time_select_o, test_tone_o;
	logic paging_block_format_o, data_alt_rate_mode_o, group_update_o, int_n_o, gu;
	logic [7:0] wr_addr_i, wr_data_i, a, d;
	logic [7:0] sh [5];
	logic [2:0] digital_gain_o, analog_gain_o;
	logic [10:0] ref_divisor_o;
	logic [12:0] synth_offset_o;
	int error_cnt = 0, tests_run = 0;
	rcr_regs dut (.*);
	rcr_host host (.mclk_i, .wr_en_o(wr_en_i), .wr_addr_o(wr_addr_i), .wr_data_o(wr_data_i));
	initial forever #12.5 mclk_i = ~mclk_i;
	task automatic chk(input string n, input logic [12:0] s, e);
		tests_run++;
		if (s !== e) begin
			error_cnt++;
			$display("mismatch %s exp %h saw %h", n, e, s);
		end
	endtask
	task automatic summarize;
		$display("%0d errors %0d checks", error_cnt, tests_run);
		if (error_cnt == 0 && tests_run > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task automatic rs;
		@(posedge mclk_i) rst_n_i <= 0;
		repeat (10) @(posedge mclk_i);
		rst_n_i <= 1;
		gu = 0;
		sh = '{rcr_pkg::VOL_RST, rcr_pkg::DIV0_RST, rcr_pkg::DIV1_RST, rcr_pkg::DIV2_RST, rcr_pkg::INT_RST};
		#1 chk("rst", {int_n_o, synth_offset_o[11:0]}, 13'h1b81);
		chk("rst2", {audio_mute_o, digital_gain_o, paging_block_format_o, test_tone_o, data_alt_rate_mode_o, group_update_o}, 13'h08);
		chk("vol", {deemphasis_time_select_o, analog_gain_o, ref_divisor_o[7:0]}, 13'hf01);
	endtask
	task automatic ev(input logic s, lo);
		@(posedge mclk_i) {receive_request_i, group_loaded_i, channel_scan_done_i} <= {1'b1, !s, s};
		gu ^= !s;
		@(posedge mclk_i) {group_loaded_i, channel_scan_done_i} <= 2'h0;
		#1 chk("evt", {group_update_o, int_n_o}, {gu, !lo});
	endtask
	initial begin
		void'($urandom(24067));
		rs();
		for (int i = 0; i < 40; i++) begin
			a = 8'h13 + 8'(i % 7);
			d = 8'($urandom);
			@(posedge mclk_i) receive_request_i <= 1'($urandom);
			host.wr(a, d);
			if (a inside {[8'h14:8'h18]}) sh[a - 8'h14] = (a == 8'h18) ? (d & 8'hf8) : d;
		end
		repeat (2) @(posedge mclk_i);
		#1 chk("mute", audio_mute_o, sh[0][7]);
		chk("tc", deemphasis_time_select_o, sh[0][6]);
		chk("dig", digital_gain_o, sh[0][5:3]);
		chk("ana", analog_gain_o, sh[0][2:0]);
		chk("div", ref_divisor_o, {sh[2][2:0], sh[1]});
		chk("ofs", synth_offset_o, {sh[3], sh[2][7:3]});
		chk("fmt", paging_block_format_o, sh[4][5]);
		chk("tone", test_tone_o, sh[4][4] & receive_request_i);
		chk("alt", data_alt_rate_mode_o, sh[4][3]);
		@(posedge mclk_i) host.wr(8'h18, 8'h57);
		ev(0, 0);
		ev(1, 1);
		chk("mode", {paging_block_format_o, test_tone_o, data_alt_rate_mode_o}, 3'h2);
		rs();
		@(posedge mclk_i) host.wr(8'h18, 8'h80);
		ev(0, 1);
		summarize();
	end
endmodule // test_receiver_control_registers
